// ---- hw/expander_map_pkg.sv ----
/*
 * Constants for the hot-plug expander bit map: word layout, expander
 * numbers, pacing period and transaction kinds.
 * Assumes a single 20 MHz core clock and a separate SMBus master engine.
 */
package expander_map_pkg;
	// Word and field layout
	localparam int WORD_W = 16;
	localparam int PIN_PER_PORT = 8;
	localparam int NUM_EXP = 5;
	localparam int EXP_IDX_W = 3;
	localparam int NUM_PORTS = 6;
	localparam int SLOT_IN_W = 4;
	localparam int SLOT_OUT_W = 4;
	// Expander numbers
	localparam logic [2:0] EXP_SLOT3_5 = 3'h1;
	localparam logic [2:0] EXP_PWRGOOD = 3'h2;
	localparam logic [2:0] EXP_SLOT1 = 3'h3;
	localparam logic [2:0] EXP_LEDS = 3'h4;
	// Bit positions
	localparam int LO_IN_LSB = 0;
	localparam int LO_OUT_LSB = 4;
	localparam int HI_IN_LSB = 8;
	localparam int HI_OUT_LSB = 12;
	localparam int PGOOD_LSB = 9;
	localparam int PGOOD_W = 5;
	localparam int LINK_LSB = 0;
	localparam int ACT_LSB = 8;
	// Output masks per expander
	localparam logic [15:0] OUT_MASK_SLOT = 16'hf0f0;
	localparam logic [15:0] OUT_MASK_SLOT1 = 16'hf000;
	localparam logic [15:0] OUT_MASK_NONE = 16'h0000;
	localparam logic [15:0] OUT_MASK_LEDS = 16'hffff;
	localparam logic [15:0] WORD_RESET = 16'hffff;
	// Update period
	localparam int UPDATE_MS = 40;
	localparam int CLK_KHZ = 20000;
	localparam int UPDATE_CYCLES = UPDATE_MS * CLK_KHZ;
	// Transaction kinds
	typedef enum logic {
		XACT_WRITE,
		XACT_READ
	} xact_kind_t;
endpackage : expander_map_pkg

// ---- hw/period_timer.sv ----
/*
 * Per-expander pacing timer: counts one update period after each start.
 * Assumes start pulses are synchronous to ref_clk.
 */
`timescale 1ns/1ps
module period_timer #(
	parameter int PERIOD = 800000
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Control
	input wire logic start,
	output logic busy
);
	initial begin
		if (PERIOD < 1) begin
			$error("period_timer: PERIOD must be at least one");
		end
	end

	logic [31:0] cnt_r; // Cycles left in period
	logic [31:0] cnt_nxt;

	// Reload on start, count down otherwise
	always_comb begin
		cnt_nxt = cnt_r;
		if (start) begin
			cnt_nxt = PERIOD;
		end else if (cnt_r != 32'h0) begin
			cnt_nxt = cnt_r - 32'h1;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 32'h0;
		end else if (clk_en) begin
			cnt_r <= cnt_nxt;
		end
	end

	assign busy = (cnt_r != 32'h0);
endmodule : period_timer

// ---- hw/expander_map.sv ----
/*
 * Packs slot hot-plug, power-good, link-up and activity signals into the
 * 16-bit words of the external expanders, and schedules write and read
 * transactions over an SMBus master engine outside this block.
 * Assumes the engine takes one request per req/ack handshake and returns
 * read data with a done pulse. Expanders 0-4 are served; slots 2 and 4
 * share expander 0 in the same layout as expander 1.
 */
`timescale 1ns/1ps

// Summary of operation
// R1 - Bit n is port n/8, pin n%8
// R2 - Expander 1 bits 0-3: slot3 inputs
// R3 - Expander 1 bits 4-7: slot3 outputs
// R4 - Expander 1 bits 8-15: slot5 signals
// R5 - Expander 2 bits 9-13: power-good inputs
// R6 - Expander 3 bits 8-15: slot1 signals
// R7 - Expander 4 bits 0-5: link-up outputs
// R8 - Expander 4 bits 8-13: activity outputs
// R9 - Board straps unused expander positions
// R10 - Inputs active low, enables active high
// R11 - Writes per expander at most per 40ms
// R12 - Interrupt reads paced at 40ms, debounce
// R13 - Round-robin transaction start across expanders
// R14 - Test mode drives software data field
module expander_map #(
	parameter int UPDATE_PERIOD = expander_map_pkg::UPDATE_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic clk_en,
	// Slot outputs from core: attn ind, power ind, power enable, interlock
	input wire logic [expander_map_pkg::SLOT_OUT_W-1:0] slot1_out,
	input wire logic [expander_map_pkg::SLOT_OUT_W-1:0] slot2_out,
	input wire logic [expander_map_pkg::SLOT_OUT_W-1:0] slot3_out,
	input wire logic [expander_map_pkg::SLOT_OUT_W-1:0] slot4_out,
	input wire logic [expander_map_pkg::SLOT_OUT_W-1:0] slot5_out,
	// Port status from core
	input wire logic [expander_map_pkg::NUM_PORTS-1:0] link_up,
	input wire logic [expander_map_pkg::NUM_PORTS-1:0] activity,
	// Slot inputs to core, active high: button, presence, fault, latch
	output logic [expander_map_pkg::SLOT_IN_W-1:0] slot1_in,
	output logic [expander_map_pkg::SLOT_IN_W-1:0] slot2_in,
	output logic [expander_map_pkg::SLOT_IN_W-1:0] slot3_in,
	output logic [expander_map_pkg::SLOT_IN_W-1:0] slot4_in,
	output logic [expander_map_pkg::SLOT_IN_W-1:0] slot5_in,
	output logic [expander_map_pkg::PGOOD_W-1:0] power_good,
	// Expander interrupt lines, active low
	input wire logic [expander_map_pkg::NUM_EXP-1:0] exp_int_n,
	// Test mode
	input wire logic expander_test_mode,
	input wire logic [expander_map_pkg::EXP_IDX_W-1:0] test_sel,
	input wire logic [expander_map_pkg::WORD_W-1:0] expander_data_field,
	input wire logic test_wr,
	// SMBus master engine request
	output logic xact_req,
	output expander_map_pkg::xact_kind_t xact_kind,
	output logic [expander_map_pkg::EXP_IDX_W-1:0] xact_exp,
	output logic [expander_map_pkg::WORD_W-1:0] xact_wdata,
	input wire logic xact_ack,
	input wire logic xact_done,
	input wire logic [expander_map_pkg::WORD_W-1:0] xact_rdata
);
	import expander_map_pkg::*;

	initial begin
		if (UPDATE_PERIOD < 1) begin
			$error("expander_map: UPDATE_PERIOD must be at least one");
		end
	end

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_REQ,
		ST_WAIT
	} state_t;

	////////////////////////////////////////////////////////////////////////
	// Word packing

	// Slot word: inputs in low nibble, outputs in high nibble of a byte
	function automatic logic [7:0] slot_byte(input logic [3:0] outs);
		slot_byte = {outs, 4'hf};
	endfunction : slot_byte

	// Output mask of one expander
	function automatic logic [15:0] out_mask(input logic [2:0] idx);
		case (idx)
			EXP_PWRGOOD: out_mask = OUT_MASK_NONE;
			EXP_SLOT1: out_mask = OUT_MASK_SLOT1;
			EXP_LEDS: out_mask = OUT_MASK_LEDS;
			default: out_mask = OUT_MASK_SLOT;
		endcase
	endfunction : out_mask

	logic [WORD_W-1:0] core_word [NUM_EXP]; // Words built from core outputs
	logic [WORD_W-1:0] want_word [NUM_EXP]; // Words after test-mode select

	// Core outputs mapped onto expander bits; input bits written high
	always_comb begin
		// R1 port n/8 pin n%8
		core_word[0] = {slot_byte(slot4_out), slot_byte(slot2_out)};
		// R3 slot3 outputs low byte
		// R4 slot5 high byte
		core_word[1] = {slot_byte(slot5_out), slot_byte(slot3_out)};
		core_word[2] = WORD_RESET;
		// R6 slot1 outputs 12-15
		core_word[3] = {slot_byte(slot1_out), 8'hff};
		// R7 link-up bits 0-5
		// R8 activity bits 8-13
		core_word[4] = {2'h0, activity, 2'h0, link_up};
		for (int i = 0; i < NUM_EXP; i++) begin
			// R14 test data replaces core
			if (expander_test_mode && test_sel == EXP_IDX_W'(i)) begin
				want_word[i] = (expander_data_field & out_mask(EXP_IDX_W'(i))) | ~out_mask(EXP_IDX_W'(i));
			end else begin
				want_word[i] = core_word[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Scheduler state

	state_t state_r, state_nxt;
	logic [EXP_IDX_W-1:0] ptr_r, ptr_nxt; // Round-robin pointer
	logic [EXP_IDX_W-1:0] cur_r, cur_nxt; // Expander in flight
	xact_kind_t kind_r, kind_nxt;
	logic [WORD_W-1:0] sent_r [NUM_EXP]; // Last written word
	logic [WORD_W-1:0] sent_nxt [NUM_EXP];
	logic [WORD_W-1:0] rd_r [NUM_EXP]; // Last read word
	logic [WORD_W-1:0] rd_nxt [NUM_EXP];
	logic [NUM_EXP-1:0] init_r, init_nxt; // First write not yet done
	logic [NUM_EXP-1:0] wpend, rpend, tstart, tbusy;
	logic [NUM_EXP-1:0] force_r, force_nxt; // Test write forces update
	logic found;
	logic [EXP_IDX_W-1:0] pick;
	xact_kind_t pick_kind;

	// One pacing timer per expander
	for (genvar g = 0; g < NUM_EXP; g++) begin : g_timer
		period_timer #(
			.PERIOD(UPDATE_PERIOD)
		) u_timer (
			.ref_clk(ref_clk),
			.rst(rst),
			.clk_en(clk_en),
			.start(tstart[g]),
			.busy(tbusy[g])
		);
	end

	// Pending work and round-robin pick
	always_comb begin
		int j; // Candidate index in rotation
		j = 0;
		found = 1'b0;
		pick = ptr_r;
		pick_kind = XACT_WRITE;
		for (int i = 0; i < NUM_EXP; i++) begin
			// Pending write when an output bit differs
			// Expanders with no output bits are never written
			wpend[i] = (out_mask(EXP_IDX_W'(i)) != 16'h0) &&
				(init_r[i] || force_r[i] || (((want_word[i] ^ sent_r[i]) & out_mask(EXP_IDX_W'(i))) != 16'h0));
			// Pending read on interrupt
			rpend[i] = !exp_int_n[i];
		end
		// R13 rotate from pointer
		for (int k = 0; k < NUM_EXP; k++) begin
			j = (int'(ptr_r) + k) % NUM_EXP;
			// R11 write paced per period
			// R12 read paced per period
			if (!found && !tbusy[j] && (wpend[j] || rpend[j])) begin
				found = 1'b1;
				pick = EXP_IDX_W'(j);
				pick_kind = wpend[j] ? XACT_WRITE : XACT_READ;
			end
		end
	end

	// Transaction sequencing
	always_comb begin
		state_nxt = state_r;
		ptr_nxt = ptr_r;
		cur_nxt = cur_r;
		kind_nxt = kind_r;
		sent_nxt = sent_r;
		rd_nxt = rd_r;
		init_nxt = init_r;
		force_nxt = force_r;
		tstart = '0;
		unique case (state_r)
			ST_IDLE: begin
				if (found) begin
					state_nxt = ST_REQ;
					cur_nxt = pick;
					kind_nxt = pick_kind;
					tstart[pick] = 1'b1;
					ptr_nxt = (pick == EXP_IDX_W'(NUM_EXP - 1)) ? '0 : pick + 1'b1;
					// Word latched at pick so write data stands with the request
					if (pick_kind == XACT_WRITE) begin
						sent_nxt[pick] = want_word[pick];
						init_nxt[pick] = 1'b0;
						force_nxt[pick] = 1'b0;
					end
				end
			end
			ST_REQ: begin
				if (xact_ack) begin
					state_nxt = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (xact_done) begin
					state_nxt = ST_IDLE;
					if (kind_r == XACT_READ) begin
						rd_nxt[cur_r] = xact_rdata;
					end
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
		// Test write after the clear, so a set in the same cycle wins
		if (expander_test_mode && test_wr && test_sel < EXP_IDX_W'(NUM_EXP)) begin
			force_nxt[test_sel] = (((expander_data_field ^ sent_r[test_sel]) & out_mask(test_sel)) != 16'h0);
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_IDLE;
			ptr_r <= '0;
			cur_r <= '0;
			kind_r <= XACT_WRITE;
			sent_r <= '{default: WORD_RESET};
			rd_r <= '{default: WORD_RESET};
			init_r <= '1;
			force_r <= '0;
		end else if (clk_en) begin
			state_r <= state_nxt;
			ptr_r <= ptr_nxt;
			cur_r <= cur_nxt;
			kind_r <= kind_nxt;
			sent_r <= sent_nxt;
			rd_r <= rd_nxt;
			init_r <= init_nxt;
			force_r <= force_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign xact_req = (state_r == ST_REQ);
	assign xact_kind = kind_r;
	assign xact_exp = cur_r;
	assign xact_wdata = sent_r[cur_r];

	// R10 inputs active low
	// R2 slot3 inputs bits 0-3
	assign slot3_in = ~rd_r[EXP_SLOT3_5][LO_IN_LSB +: SLOT_IN_W];
	// R4 slot5 inputs 8-11
	assign slot5_in = ~rd_r[EXP_SLOT3_5][HI_IN_LSB +: SLOT_IN_W];
	assign slot2_in = ~rd_r[0][LO_IN_LSB +: SLOT_IN_W];
	assign slot4_in = ~rd_r[0][HI_IN_LSB +: SLOT_IN_W];
	// R6 slot1 inputs 8-11
	assign slot1_in = ~rd_r[EXP_SLOT1][HI_IN_LSB +: SLOT_IN_W];
	// R5 power-good bits 9-13
	assign power_good = ~rd_r[EXP_PWRGOOD][PGOOD_LSB +: PGOOD_W];
	// R9 strapped bits ignored
endmodule : expander_map

// ---- test/exp_engine_model.sv ----
/*
 * Model of the SMBus master engine and the expander chips behind it.
 * Assumes the block holds its request until acknowledged.
 */
`timescale 1ns/1ps
module exp_engine_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Request side
	input wire logic xact_req,
	input wire logic [2:0] xact_exp,
	output logic xact_ack,
	output logic xact_done,
	output logic [15:0] xact_rdata,
	// Pin levels and pacing
	input wire logic [15:0] pin_word [5],
	input wire logic slow
);
	logic [3:0] cnt_r; // Zero while idle
	logic [3:0] dly; // Ack delay
	assign dly = slow ? 4'h6 : 4'h1;
	////////////////////////////////////////////////////////////
	// Ack after a delay, done three cycles later
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 4'h0;
			xact_ack <= 1'b0;
			xact_done <= 1'b0;
			xact_rdata <= 16'h0;
		end else begin
			xact_ack <= 1'b0;
			xact_done <= 1'b0;
			// Data not held outside done
			xact_rdata <= ~xact_rdata;
			if (cnt_r == 4'h0) begin
				if (xact_req && !xact_ack) cnt_r <= 4'h1;
			end else begin
				cnt_r <= cnt_r + 4'h1;
				if (cnt_r == dly) xact_ack <= 1'b1;
				if (cnt_r == dly + 4'h3) begin
					cnt_r <= 4'h0;
					xact_done <= 1'b1;
					// pin packing, bits 0-3 of expanders 2 and 3 strapped high
					xact_rdata <= pin_word[xact_exp] | ((xact_exp == 3'h2 || xact_exp == 3'h3) ? 16'h000f : 16'h0);
				end
			end
		end
	end
endmodule : exp_engine_model

// ---- test/expander_map_properties.sv ----
/*
 * Checker for the expander transaction scheduler.
 * Assumes it is bound to the block's top module.
 */
`timescale 1ns/1ps
module expander_map_properties
	import expander_map_pkg::*;
#(
	parameter int UPDATE_PERIOD = UPDATE_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic expander_test_mode,
	input wire logic xact_req,
	input wire expander_map_pkg::xact_kind_t xact_kind,
	input wire logic [2:0] xact_exp,
	input wire logic [15:0] xact_wdata,
	input wire logic xact_ack
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic req_q_r; // Request seen last cycle
	int cnt_r [5]; // Quiet time left per expander
	logic wr; // Write request on the bus
	assign wr = xact_req && xact_kind == XACT_WRITE;
	////////////////////////////////////////////////////////////
	// Period since last start, per expander
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			req_q_r <= 1'b0;
			for (int i = 0; i < 5; i++) cnt_r[i] <= 0;
		end else begin
			req_q_r <= xact_req;
			for (int i = 0; i < 5; i++) begin
				if (xact_req && !req_q_r && xact_exp == i) cnt_r[i] <= UPDATE_PERIOD - 2;
				else if (cnt_r[i] > 0) cnt_r[i] <= cnt_r[i] - 1;
			end
		end
	end
	a_req_hold: assert property (xact_req && !xact_ack |=> xact_req)
		else $error("request dropped before ack");
	a_req_drop: assert property (xact_ack |=> !xact_req [*2])
		else $error("request stands after ack");
	a_fields_hold: assert property (xact_req && !xact_ack |=> $stable(xact_exp) && $stable(xact_wdata))
		else $error("request fields moved");
	a_pgood_ro: assert property (wr |-> xact_exp != EXP_PWRGOOD)
		else $error("power good expander written");
	a_slot35_inputs: assert property (wr && xact_exp == EXP_SLOT3_5 |-> xact_wdata[3:0] == 4'hf && xact_wdata[11:8] == 4'hf)
		else $error("slot input bits not high");
	a_slot1_inputs: assert property (wr && xact_exp == EXP_SLOT1 |-> xact_wdata[11:8] == 4'hf)
		else $error("slot one input bits not high");
	a_led_resv: assert property (wr && xact_exp == EXP_LEDS && !expander_test_mode |-> xact_wdata[7:6] == 2'h0 && xact_wdata[15:14] == 2'h0)
		else $error("reserved led bits driven");
	a_pace_gap: assert property (xact_req && !req_q_r |-> cnt_r[xact_exp] == 0)
		else $error("expander served twice in one period");
	c_read: cover property (xact_req && xact_kind == XACT_READ);
	c_led_write: cover property (wr && xact_exp == EXP_LEDS);
	c_slow_ack: cover property (xact_req [*5]);
endmodule : expander_map_properties
bind expander_map expander_map_properties #(.UPDATE_PERIOD(UPDATE_PERIOD)) u_props (.ref_clk(ref_clk), .rst(rst),
	.expander_test_mode(expander_test_mode), .xact_req(xact_req), .xact_kind(xact_kind), .xact_exp(xact_exp),
	.xact_wdata(xact_wdata), .xact_ack(xact_ack));

// ---- test/hotplug_expander_bit_map_test.sv ----
/*
 * Self-checking bench: reset writes, interrupt reads, updates, test mode.
 * Assumes the engine model answers every request.
 */
`timescale 1ns/1ps
module hotplug_expander_bit_map_test;
	import expander_map_pkg::*;
	logic ref_clk = 0, rst = 1, en = 1, slow = 0, tm = 0, test_wr = 0, ack, done, req, k;
	logic [3:0] s1 = 4'h5, s2 = 4'h6, s3 = 4'h9, s4 = 4'h3, s5 = 4'ha, i1, i2, i3, i4, i5;
	logic [5:0] link_up = 6'h2d, activity = 6'h13;
	logic [4:0] pg, int_n = 5'h1f;
	logic [2:0] sel = 3'h0, xe, e;
	logic [15:0] field = 16'h0, wd, rd, w;
	logic [15:0] pins [5] = '{default: 16'hffff};
	xact_kind_t kind;
	int error_cnt = 0, n_compared = 0;
	always #25 ref_clk = ~ref_clk;
	expander_map #(.UPDATE_PERIOD(20)) dut (.ref_clk(ref_clk), .rst(rst), .clk_en(en), .slot1_out(s1),
		.slot2_out(s2), .slot3_out(s3), .slot4_out(s4), .slot5_out(s5), .link_up(link_up), .activity(activity),
		.slot1_in(i1), .slot2_in(i2), .slot3_in(i3), .slot4_in(i4), .slot5_in(i5), .power_good(pg),
		.exp_int_n(int_n), .expander_test_mode(tm), .test_sel(sel), .expander_data_field(field),
		.test_wr(test_wr), .xact_req(req), .xact_kind(kind), .xact_exp(xe), .xact_wdata(wd), .xact_ack(ack),
		.xact_done(done), .xact_rdata(rd));
	exp_engine_model u_model (.ref_clk(ref_clk), .rst(rst), .xact_req(req), .xact_exp(xe), .xact_ack(ack),
		.xact_done(done), .xact_rdata(rd), .pin_word(pins), .slow(slow));
	////////////////////////////////////////////////////////////
	task automatic complete_run;
		$display("errors=%0d compared=%0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	task automatic check(input logic [15:0] seen, input logic [15:0] expv);
		n_compared++;
		if (seen !== expv) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, expv);
		end
	endtask : check
	// One clock, then the fixed drive delay
	task automatic tick;
		@(posedge ref_clk);
		#2;
	endtask : tick
	// Wait for next accepted request of the given kind and expander, then its completion
	task automatic find(input logic fk, input logic [2:0] fe);
		int i, j, n;
		for (j = 0; j < 8; j++) begin
			for (i = 0; i < 400 && !(req === 1'b1 && ack === 1'b1); i++) tick();
			k = kind;
			e = xe;
			w = wd;
			for (n = 0; n < 400 && done !== 1'b1; n++) tick();
			repeat (2) tick();
			if (i >= 400 || n >= 400) j = 8;
			else if (k === fk && e === fe) return;
		end
		error_cnt++;
		complete_run();
	endtask : find
	////////////////////////////////////////////////////////////
	// Init writes in rotation with packed words
	task automatic t_init;
		logic [2:0] et [4] = '{3'h0, 3'h1, 3'h3, 3'h4};
		logic [15:0] wt [4] = '{16'h3f6f, 16'haf9f, 16'h5f00, 16'h132d};
		logic [15:0] mt [4] = '{16'hffff, 16'hffff, 16'hff00, 16'hffff};
		for (int n = 0; n < 4; n++) begin
			find(1'b0, et[n]);
			check(w & mt[n], wt[n]);
		end
	endtask : t_init
	// Interrupt reads, inputs inverted
	task automatic t_read;
		logic [15:0] pt [4] = '{16'h3ac5, 16'h5a3c, 16'hd5ff, 16'h93ff};
		slow = 1;
		for (int n = 0; n < 4; n++) begin
			pins[n] = pt[n];
			int_n[n] = 1'b0;
			find(1'b1, n[2:0]);
			int_n[n] = 1'b1;
			if (n == 0) check({8'h0, i4, i2}, 16'h005a);
			if (n == 1) check({i5, i3}, 16'h0053);
			if (n == 2) check({11'h0, pg}, 16'h0015);
			if (n == 3) check({12'h0, i1}, 16'h000c);
		end
		slow = 0;
	endtask : t_read
	// Core output change leads to paced writes
	task automatic t_change;
		en = 0;
		s3 = 4'h6;
		link_up = 6'h12;
		activity = 6'h21;
		// Frozen block starts no transaction
		repeat (4) tick();
		check({15'h0, req}, 16'h0000);
		en = 1;
		// Pointer stands after expander 3, so expander 4 comes first
		find(1'b0, 3'h4);
		check(w, 16'h2112);
		find(1'b0, 3'h1);
		check(w & 16'h00f0, 16'h0060);
	endtask : t_change
	// Test mode drives the data field
	task automatic t_test(input logic [2:0] s, input logic [15:0] f, input logic [15:0] x);
		tm = 1;
		sel = s;
		field = f;
		test_wr = 1;
		@(posedge ref_clk);
		#2 test_wr = 0;
		find(1'b0, s);
		check(w, x);
	endtask : t_test
	initial begin
		repeat (20) @(posedge ref_clk);
		#2 rst = 0;
		t_init();
		t_read();
		t_change();
		t_test(3'h4, 16'h2a15, 16'h2a15);
		t_test(3'h1, 16'h50a0, 16'h5faf);
		complete_run();
	end
endmodule : hotplug_expander_bit_map_test
